// [design/itf_framer.sv]
// Serial time-division framer toward up to three line transceiver chips
`timescale 1ns/1ps
// Operation
// - Frames start on the shared 8 kHz sync
// - Send bits on bit clock rising edge
// - Sample received bits on falling edge
// - 3.072 MHz for one chip, faster otherwise; the core divides 25 MHz by 8, so one chip gets 3.125 MHz
// - Master clock except trunk line mode
// - Ping-pong mode: data bit only per slot
// - S/T mode: data bit plus control bit
// - Decode received pairs: zero, one, echo, frame
// - Encode zero and one only; never 1,0
// - Data bit goes before control bit
// - B data MSB first, words LSB first
// - Unused bits are ignored on receive
// - Channels strictly 0 to 7 per chip
// - Receive runs two channels ahead
// - Chip word then channel words, 32-bit
// - Chip command word every frame
// - Channel word mixes register and RAM fields
// - Fixed low field layout of channel word
// - Chip delay byte stored to status register
// - Test flags of channel status ignored
// - Slip, violation, state readable per channel
module itf_framer #(
    parameter int NCHIP_MAX = itf_pkg::MAX_CHIPS,
    parameter int NCHAN     = itf_pkg::CHAN_PER_CHIP
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        frame_sync,
    input  wire logic        ref_clock_in,
    input  wire logic        rx_serial_line,
    input  wire logic        status_line,
    input  wire logic [1:0]  chips_m1,
    input  wire logic [2:0]  line_mode,
    input  wire logic [95:0] chip_command_register,
    input  wire logic [31:0] channel_command_register,
    input  wire logic        tx_we,
    input  wire logic [4:0]  tx_addr,
    input  wire logic [7:0]  tx_data,
    input  wire logic [4:0]  tx_ctrl,
    input  wire logic [4:0]  rx_rd_addr,
    output logic             bit_clock_out,
    output logic             clock_master,
    output logic             tx_serial_line,
    output logic             command_line,
    output logic [23:0]      chip_status_register,
    output logic [7:0]       rx_rd_data,
    output logic [3:0]       rx_rd_status,
    output logic [1:0]       rx_rd_pair_flags
);
    localparam int NTOT = NCHIP_MAX * NCHAN;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0]  rst_s;
        logic [1:0]  fs_s;
        logic [1:0]  rx_s;
        logic [1:0]  st_s;
        logic        fs_d;
        logic        bclk;
        logic        master;
        logic        tx;
        logic        cmd;
        logic [1:0]  pair;     // Received pair: bit0 data, bit1 ctrl
        logic        pair_ph;
        logic [7:0]  rx_sh;
        logic [31:0] st_sh;
        logic [23:0] chip_st;
        logic [7:0]  rd_data;
        logic [3:0]  rd_stat;
        logic [1:0]  rd_flags;
    } itf_fr_type;

    itf_fr_type s_r, s_nxt;

    itf_bit_if bif ();
    logic        bclk_int;
    logic        fs_edge;
    logic [31:0] cmd_word;
    logic [4:0]  cur_ch, rx_ch, st_ch;
    logic [2:0]  bit_in_byte;
    logic [4:0]  word_bit;
    logic [7:0]  txd_byte;
    logic [4:0]  txd_ctrl;
    logic        rx_commit, st_commit;
    logic [7:0]  rx_store;
    logic [31:0] st_store;
    logic [31:0] rxd_q;
    logic [31:0] rxs_q;
    logic        data_zone;
    logic [4:0]  tx_slots;
    logic        st_mode, sub_cycle;
    logic [1:0]  cur_chip, st_chip;
    logic        chip_slot;
    logic [7:0]  txd_mem [NTOT];
    logic [4:0]  txc_mem [NTOT];

    assign fs_edge = s_r.fs_s[1] & ~s_r.fs_d; // Rising edge of sync
    assign st_mode = (line_mode != itf_pkg::MODE_PPONG);

    itf_clk_gen #(.HALF_DIV(itf_pkg::HALF_DIV_ONE)) u_clk (
        .clk        (clk),
        .rst_sync_b (s_r.rst_s[1]),
        .fs_edge    (fs_edge),
        .chips_m1   (chips_m1),
        .bclk       (bclk_int),
        .bus        (bif.gen)
    );

    // ****************************************************************
    // Bit position decode
    // ****************************************************************
    // S/T mode uses two link bits per line bit, so a byte spans 16
    always_comb begin
        sub_cycle   = st_mode ? bif.bit_idx[0] : 1'b0;
        bit_in_byte = st_mode ? bif.bit_idx[3:1] : bif.bit_idx[2:0];
        cur_ch      = 5'((st_mode ? bif.bit_idx[15:4] : bif.bit_idx[15:3]) % NTOT);
        tx_slots    = 5'((32'(chips_m1) + 1) * NCHAN);
        // Data slots end after the last chip; later bits must not wrap onto channel 0
        data_zone   = ((st_mode ? {1'b0, bif.bit_idx[15:4]} : bif.bit_idx[15:3])
                      < 13'(tx_slots));
        // Shift wraps over the channels in use, not the full table
        rx_ch       = 5'((32'(cur_ch) + itf_pkg::RX_CHAN_SHIFT) % 32'(tx_slots));
        word_bit    = bif.bit_idx[4:0];
        // Command stream: per chip, 1 chip word then 8 channel words
        cur_chip    = 2'((bif.bit_idx >> 5) / (NCHAN + 1));
        st_ch       = 5'(32'(cur_chip) * NCHAN
                      + 32'(((bif.bit_idx >> 5) % (NCHAN + 1))) - 1);
        chip_slot   = (((bif.bit_idx >> 5) % (NCHAN + 1)) == 0);
        st_chip     = cur_chip;
    end

    // Transmit data RAM holds the byte and RAM-resident command fields
    always_ff @(posedge clk) begin
        if (tx_we) begin
            txd_mem[tx_addr] <= tx_data;
            txc_mem[tx_addr] <= tx_ctrl;
        end
    end
    assign txd_byte = txd_mem[cur_ch];
    assign txd_ctrl = txc_mem[st_ch];

    // Command word assembly
    always_comb begin
        if (chip_slot) begin
            cmd_word = chip_command_register[32'(st_chip) * 32 +: 32];
        end else begin
            cmd_word = channel_command_register;
            cmd_word[itf_pkg::CC_ST_POS]    = txd_ctrl[0];
            cmd_word[itf_pkg::CC_MULTIFRAME_SYNC_POS] = txd_ctrl[1];
            cmd_word[itf_pkg::CC_STATE_MACHINE_INIT_LO +: 3] = txd_ctrl[4:2];
        end
    end

    // ****************************************************************
    // Receive stores: data bytes and channel status words
    // ****************************************************************
    assign rx_commit = bif.sample && (bit_in_byte == 3'h7) && (sub_cycle == st_mode)
                       && data_zone;
    // In S/T mode the last sampled bit is a control bit, so take the held data bit
    assign rx_store  = st_mode ? {s_r.rx_sh[6:0], s_r.pair[0]}
                               : {s_r.rx_sh[6:0], s_r.rx_s[1]};
    assign st_commit = bif.sample && (word_bit == 5'h1f) && !chip_slot
                       && (cur_chip <= chips_m1);
    assign st_store  = {s_r.st_s[1], s_r.st_sh[31:1]};

    itf_chan_ram #(.DEPTH(NTOT), .AW(5)) u_rxd (
        .clk   (clk),
        .we    (rx_commit),
        .waddr (rx_ch),
        .wdata ({24'h0000_00, rx_store}),
        .raddr (rx_rd_addr),
        .rdata (rxs_q)
    );
    // Only slip, violation and state kept; test flags dropped
    itf_chan_ram #(.DEPTH(NTOT), .AW(5)) u_rxs (
        .clk   (clk),
        .we    (st_commit),
        .waddr (st_ch),
        .wdata ({28'h000_0000, st_store[3:0]}),
        .raddr (rx_rd_addr),
        .rdata (rxd_q)
    );

    // ****************************************************************
    // Main next-state logic
    // ****************************************************************
    always_comb begin
        s_nxt        = s_r;
        s_nxt.rst_s  = {s_r.rst_s[0], 1'b1};
        s_nxt.fs_s   = {s_r.fs_s[0], frame_sync};
        s_nxt.rx_s   = {s_r.rx_s[0], rx_serial_line};
        s_nxt.st_s   = {s_r.st_s[0], status_line};
        s_nxt.fs_d   = s_r.fs_s[1];
        s_nxt.bclk   = bclk_int;
        // Trunk mode takes the reference from the chip
        s_nxt.master = (line_mode != itf_pkg::MODE_TRUNK);
        // Launch on rising edge: data bit then control bit
        if (bif.launch) begin
            if (!data_zone) begin
                s_nxt.tx = 1'b0;
            end else if (!st_mode) begin
                s_nxt.tx = txd_byte[3'h7 - bit_in_byte];
            end else if (!sub_cycle) begin
                s_nxt.tx = txd_byte[3'h7 - bit_in_byte];
            end else begin
                // Control bit always sent as 0: 1,0 never sent
                s_nxt.tx = 1'b0;
            end
            s_nxt.cmd = (cur_chip <= chips_m1) ? cmd_word[word_bit] : 1'b0;
        end
        // Sample on falling edge
        if (bif.sample) begin
            if (st_mode && !sub_cycle) begin
                s_nxt.pair[0] = s_r.rx_s[1];
            end else if (st_mode) begin
                s_nxt.pair[1] = s_r.rx_s[1];
                // Decode pair: framing and echo are not payload
                if ({s_r.rx_s[1], s_r.pair[0]} == itf_pkg::ST_ZERO ||
                    {s_r.rx_s[1], s_r.pair[0]} == itf_pkg::ST_ONE)
                    s_nxt.rx_sh = {s_r.rx_sh[6:0], s_r.pair[0]};
            end else begin
                s_nxt.rx_sh = {s_r.rx_sh[6:0], s_r.rx_s[1]};
            end
            s_nxt.st_sh = {s_r.st_s[1], s_r.st_sh[31:1]};
            // Chip delay byte
            if (chip_slot && word_bit == 5'h1f && cur_chip <= chips_m1)
                s_nxt.chip_st[32'(cur_chip) * 8 +: 8] = st_store[7:0];
        end
        s_nxt.rd_data  = rxs_q[7:0];
        s_nxt.rd_stat  = rxd_q[3:0];
        s_nxt.rd_flags = s_r.pair;
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // Outputs from flip-flops
    assign bit_clock_out        = s_r.bclk;
    assign clock_master         = s_r.master;
    assign tx_serial_line       = s_r.tx;
    assign command_line         = s_r.cmd;
    assign chip_status_register = s_r.chip_st;
    assign rx_rd_data           = s_r.rd_data;
    assign rx_rd_status         = s_r.rd_stat;
    assign rx_rd_pair_flags     = s_r.rd_flags;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_master_mode: assert property (@(posedge clk) disable iff (!s_r.rst_s[1])
        ##1 (s_r.master == ($past(line_mode) != itf_pkg::MODE_TRUNK)))
        else $error("clock master wrong");
    a_no_ten_pair: assert property (@(posedge clk) disable iff (!s_r.rst_s[1])
        (bif.launch && st_mode && sub_cycle) |=> !s_r.tx)
        else $error("pair 1,0 launched");
    a_rx_shift: assert property (@(posedge clk) disable iff (!s_r.rst_s[1])
        rx_commit |-> rx_ch == 5'((32'(cur_ch) + 2) % (32'(chips_m1) * 8 + 8)))
        else $error("receive shift wrong");
    a_idle_tx: assert property (@(posedge clk) disable iff (!s_r.rst_s[1])
        (bif.launch && !data_zone) |=> !s_r.tx)
        else $error("unused slot driven");
    a_chip_word: assert property (@(posedge clk) disable iff (!s_r.rst_s[1])
        (bif.launch && chip_slot && cur_chip == 2'h0) |=>
        s_r.cmd == $past(chip_command_register[word_bit]))
        else $error("chip word bit wrong");
    c_st_frame: cover property (@(posedge clk) st_mode && fs_edge);
    c_pp_frame: cover property (@(posedge clk) !st_mode && fs_edge);
    c_rx_store: cover property (@(posedge clk) rx_commit);
    c_st_store: cover property (@(posedge clk) st_commit);
endmodule : itf_framer

// [design/itf_pkg.sv]
// Package with constants of the transceiver serial framer
package itf_pkg;

    // ****************************************************************
    // Frame geometry
    // ****************************************************************
    localparam int CHAN_PER_CHIP  = 8;
    localparam int MAX_CHIPS      = 3;
    localparam int WORD_BITS      = 32;
    localparam int BYTE_BITS      = 8;
    localparam int RX_CHAN_SHIFT  = 2;
    localparam int FRAME_RATE_HZ  = 8000;
    localparam int BASE_RATE_KHZ  = 3072;
    localparam int CLK_RATE_KHZ   = 25000;
    // Core clock cycles per link bit half, one chip
    localparam int HALF_DIV_ONE   = CLK_RATE_KHZ / (2 * BASE_RATE_KHZ);
    localparam int FRAME_CYCLES   = CLK_RATE_KHZ * 1000 / FRAME_RATE_HZ;

    // ****************************************************************
    // Per-channel command word fields
    // ****************************************************************
    localparam int CC_WR_POS      = 0;
    localparam int CC_RD_POS      = 1;
    localparam int CC_ST_POS      = 2;
    localparam int CC_MODE_SELECT_LO    = 3;
    localparam int CC_MODE_LO     = 5;
    localparam int CC_MULTIFRAME_SYNC_POS   = 27;
    localparam int CC_STATE_MACHINE_INIT_LO    = 28;

    // Per-channel status word fields
    localparam int CS_RECEIVE_STATE_LO    = 0;
    localparam int CS_FRAMING_ERROR_VIOLATION_POS    = 2;
    localparam int CS_SLIP_POS    = 3;

    // Line mode values of the mode field
    localparam logic [2:0] MODE_TRUNK = 3'h0;
    localparam logic [2:0] MODE_SUBSC = 3'h1;
    localparam logic [2:0] MODE_PPONG = 3'h2;

    // S/T pair codes, control in bit 1, data in bit 0
    localparam logic [1:0] ST_ZERO    = 2'h0;
    localparam logic [1:0] ST_ONE     = 2'h1;
    localparam logic [1:0] ST_ECHO    = 2'h2;
    localparam logic [1:0] ST_FRAME   = 2'h3;

    // Reset values
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;

endpackage : itf_pkg

// [design/itf_bit_if.sv]
// Interface carrying link bit timing between framer modules
`timescale 1ns/1ps
interface itf_bit_if;
    logic launch;     // Rising edge of bit clock
    logic sample;     // Falling edge of bit clock
    logic frame_go;   // First bit of a frame
    logic [15:0] bit_idx; // Bit position in frame

    modport gen (output launch, output sample, output frame_go, output bit_idx);
    modport use_ (input launch, input sample, input frame_go, input bit_idx);
endinterface : itf_bit_if

// [design/itf_clk_gen.sv]
// Bit clock generator locked to frame sync
`timescale 1ns/1ps
module itf_clk_gen #(
    parameter int HALF_DIV = 4
) (
    input  wire logic  clk,
    input  wire logic  rst_sync_b,
    input  wire logic  fs_edge,
    input  wire logic [1:0] chips_m1,
    output logic       bclk,
    itf_bit_if.gen     bus
);
    typedef struct packed {
        logic [7:0]  div;
        logic        bclk;
        logic        launch;
        logic        sample;
        logic        go;
        logic [15:0] idx;
    } itf_cg_type;

    itf_cg_type s_r, s_nxt;
    logic [7:0] half;

    // ****************************************************************
    // Divider: more chips, faster clock
    // ****************************************************************
    // Half period divides by chip count so every chip's words fit the frame
    always_comb begin
        half = 8'(HALF_DIV / (32'(chips_m1) + 1));
        if (half == 8'h00)
            half = 8'h01;
    end

    // Divider and bit counter; frame sync restarts both
    always_comb begin
        s_nxt        = s_r;
        s_nxt.launch = 1'b0;
        s_nxt.sample = 1'b0;
        s_nxt.go     = 1'b0;
        if (fs_edge) begin
            s_nxt.div    = 8'h00;
            s_nxt.bclk   = 1'b1;
            s_nxt.launch = 1'b1;
            s_nxt.go     = 1'b1;
            s_nxt.idx    = 16'h0000;
        end else if (s_r.div + 8'h01 >= half) begin
            s_nxt.div  = 8'h00;
            s_nxt.bclk = ~s_r.bclk;
            if (s_r.bclk) begin
                s_nxt.sample = 1'b1;
            end else begin
                s_nxt.launch = 1'b1;
                s_nxt.idx    = s_r.idx + 16'h0001;
            end
        end else begin
            s_nxt.div = s_r.div + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign bclk         = s_r.bclk;
    assign bus.launch   = s_r.launch;
    assign bus.sample   = s_r.sample;
    assign bus.frame_go = s_r.go;
    assign bus.bit_idx  = s_r.idx;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_launch_rise: assert property (@(posedge clk) disable iff (!rst_sync_b)
        s_r.launch |-> s_r.bclk) else $error("launch without rising clock");
    a_sample_fall: assert property (@(posedge clk) disable iff (!rst_sync_b)
        s_r.sample |-> !s_r.bclk) else $error("sample without falling clock");
    a_frame_start: assert property (@(posedge clk) disable iff (!rst_sync_b)
        fs_edge |=> (s_r.idx == 16'h0000 && s_r.go)) else $error("frame not aligned");
    c_frame_go: cover property (@(posedge clk) disable iff (!rst_sync_b) s_r.go);
endmodule : itf_clk_gen

// [design/itf_chan_ram.sv]
// Small per-channel word store used for received data bytes and status words
`timescale 1ns/1ps
module itf_chan_ram #(
    parameter int DEPTH = 24,
    parameter int AW    = 5
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [31:0]   wdata,
    input  wire logic [AW-1:0] raddr,
    output logic [31:0]        rdata
);
    logic [31:0] mem [DEPTH];

    // Write port, no reset: contents are written by the receive logic
    always_ff @(posedge clk) begin
        if (we)
            mem[waddr] <= wdata;
    end

    // Asynchronous read keeps the readback path one cycle shorter
    assign rdata = mem[raddr];
endmodule : itf_chan_ram

// [bench/itf_chip_model.sv]
// Behavioural model of one line transceiver chip sitting at link channels 0..7
`timescale 1ns/1ps
module itf_chip_model (
    input  logic        bit_clock_out,
    input  logic        frame_sync,
    input  logic        tx_serial_line,
    input  logic        command_line,
    input  logic [7:0]  delay_val,
    output logic        rx_serial_line,
    output logic        status_line,
    output logic [15:0] tx_cap,
    output logic [63:0] cmd_cap,
    output int          bad_pairs
);
    int          idx;
    time         t_sync;
    logic [7:0]  b;
    logic [31:0] w;

    initial begin
        idx = 1000;
        t_sync = 0;
        rx_serial_line = 1'b0;
        status_line = 1'b0;
        tx_cap = '0;
        cmd_cap = '0;
        bad_pairs = 0;
    end

    // Bit count restarts with each frame strobe; the chip sits at slot 0..7
    always @(posedge frame_sync) begin
        idx = -1;
        t_sync = $time;
    end

    // Answers change just after each rising edge, so they settle before the falling one.
    // Edges right after the strobe belong to the old frame and are skipped.
    always @(posedge bit_clock_out) begin
        if ($time - t_sync > 100) begin
            idx = idx + 1;
            b = 8'h30 + 8'((idx / 8 + 2) % 8);
            rx_serial_line = (idx < 64) ? b[7 - idx % 8] : ~rx_serial_line;
            w = (idx < 32) ? {24'h5A_5A5A, delay_val}
                           : {28'h5A5_A5A7, 4'h9 ^ 4'((idx - 32) / 32)};
            status_line = (idx < 288) ? w[idx % 32] : ~status_line;
        end
    end

    // Capture what the framer launched on the rising edge
    always @(negedge bit_clock_out) begin
        if (idx >= 0 && idx < 16) begin
            tx_cap[15 - idx] = tx_serial_line;
            if (idx % 2 == 1 && tx_serial_line && !tx_cap[16 - idx]) bad_pairs++;
        end
        if (idx >= 0 && idx < 64) cmd_cap[idx] = command_line;
    end
endmodule : itf_chip_model

// [bench/tb_top.sv]
// Self-checking testbench of the transceiver serial framer
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    logic        clk, rst_b, frame_sync, ref_clock_in, rx_serial_line, status_line;
    logic        tx_we, bit_clock_out, clock_master, tx_serial_line, command_line;
    logic [1:0]  chips_m1;
    logic [2:0]  line_mode;
    logic [4:0]  tx_addr, tx_ctrl, rx_rd_addr;
    logic [7:0]  tx_data, rx_rd_data, d;
    logic [3:0]  rx_rd_status, s;
    logic [23:0] chip_status_register;
    logic [15:0] tx_cap, e;
    logic [63:0] cmd_cap;
    int          bad_pairs, fcnt, c, k, n_errors, check_count;

    itf_framer itf_framer_i (.clk(clk), .rst_b(rst_b), .frame_sync(frame_sync),
        .ref_clock_in(ref_clock_in), .rx_serial_line(rx_serial_line),
        .status_line(status_line), .chips_m1(chips_m1), .line_mode(line_mode),
        .chip_command_register({32'h0000_0111, 32'h0000_0222, 32'h0000_0A58}),
        .channel_command_register(32'h9000_00B2), .tx_we(tx_we), .tx_addr(tx_addr),
        .tx_data(tx_data), .tx_ctrl(tx_ctrl), .rx_rd_addr(rx_rd_addr),
        .bit_clock_out(bit_clock_out), .clock_master(clock_master),
        .tx_serial_line(tx_serial_line), .command_line(command_line),
        .chip_status_register(chip_status_register), .rx_rd_data(rx_rd_data),
        .rx_rd_status(rx_rd_status), .rx_rd_pair_flags());
    itf_chip_model itf_chip_model_i (.bit_clock_out(bit_clock_out),
        .frame_sync(frame_sync), .tx_serial_line(tx_serial_line),
        .command_line(command_line), .delay_val(8'hA7), .rx_serial_line(rx_serial_line),
        .status_line(status_line), .tx_cap(tx_cap), .cmd_cap(cmd_cap),
        .bad_pairs(bad_pairs));

    // ****************************************************************
    // Clocks and frame strobe
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Reference runs unrelated in phase to the core clock
    initial begin
        ref_clock_in = 1'b0;
        #7;
        forever #160 ref_clock_in = ~ref_clock_in;
    end
    // 8 kHz strobe, 16 cycles wide so the synchroniser sees it
    always @(posedge clk) begin
        fcnt <= (fcnt == itf_pkg::FRAME_CYCLES - 1) ? 0 : fcnt + 1;
        frame_sync <= (fcnt < 16);
    end

    // ****************************************************************
    // Access tasks
    // ****************************************************************
    task automatic wait_frames(int n);
        repeat (n) @(posedge frame_sync);
        @(posedge clk);
    endtask : wait_frames

    task automatic tx_write(logic [4:0] a, logic [7:0] v, logic [4:0] ct);
        tx_we <= 1'b1;
        tx_addr <= a;
        tx_data <= v;
        tx_ctrl <= ct;
        @(posedge clk);
        tx_we <= 1'b0;
        @(posedge clk);
    endtask : tx_write

    // Read data lands one cycle after the address; take it one edge later
    task automatic rx_read(logic [4:0] a, output logic [7:0] v, output logic [3:0] st);
        rx_rd_addr <= a;
        repeat (2) @(posedge clk);
        v = rx_rd_data;
        st = rx_rd_status;
    endtask : rx_read

    // Strobe-to-clock lag and bit clock period for a given chip count
    task automatic bclk_check(int n);
        time ts;
        time tr;
        @(posedge frame_sync);
        ts = $time;
        @(posedge bit_clock_out);
        `CHK(($time - ts) <= 240, 1'b1)
        repeat (200) @(posedge clk);
        @(posedge bit_clock_out);
        tr = $time;
        @(posedge bit_clock_out);
        `CHK(32'(($time - tr) / 40), 32'(2 * (itf_pkg::HALF_DIV_ONE / (n + 1))))
        @(posedge clk);
    endtask : bclk_check

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // Watchdog: about 14 frames are needed, this allows over 25
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        close_out();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {rst_b, fcnt, frame_sync, tx_we, tx_addr, tx_data, tx_ctrl} = '0;
        {chips_m1, rx_rd_addr, n_errors, check_count} = '0;
        line_mode = itf_pkg::MODE_SUBSC;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wait_frames(2);
        // Status strobe, multiframe flag and init code all set, unlike the register copy
        tx_write(5'h00, 8'hC5, 5'b10111);
        for (k = 0; k < 3; k++) begin
            line_mode <= 3'(k);
            repeat (4) @(posedge clk);
            `CHK(clock_master, 1'(k != 0))
        end
        line_mode <= itf_pkg::MODE_SUBSC;
        wait_frames(3);
        for (k = 0; k < 8; k++) begin
            e[15 - 2 * k] = 8'hC5 >> (7 - k);
            e[14 - 2 * k] = 1'b0;
        end
        `CHK(tx_cap, e)
        `CHK(bad_pairs, 0)
        `CHK(cmd_cap[31:0] & 32'h0000_0FF8, 32'h0000_0A58)
        `CHK(cmd_cap[63:32] & 32'hF800_00FF, 32'hD800_00B6)
        `CHK(chip_status_register[7:0], 8'hA7)
        for (c = 0; c < 8; c++) begin
            rx_read(5'(c), d, s);
            `CHK(s, 4'h9 ^ 4'(c))
        end
        // Plain data slots: the same byte goes out without control bits
        line_mode <= itf_pkg::MODE_PPONG;
        wait_frames(3);
        `CHK(tx_cap[15:8], 8'hC5)
        for (c = 0; c < 8; c++) begin
            rx_read(5'(c), d, s);
            `CHK(d, 8'h30 + 8'(c))
        end
        for (k = 0; k < 3; k++) begin
            chips_m1 <= 2'(k);
            wait_frames(1);
            bclk_check(k);
        end
        close_out();
    end
endmodule : tb_top
